// [tb/fspc_props.sv]
// concurrent checks on the link between host end and controller
`timescale 1ns/1ns
`default_nettype none
module fspc_props (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic       spm,
  input wire logic       lpm,
  input wire logic       ee_busy,
  input wire logic [7:0] ctrl_rdata,
  input wire logic       rd_ack,
  input wire logic       halt,
  input wire logic       rww_block,
  input wire logic       irq
);
  // one clock domain, reset kills every check
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////
  AST_IRQ_LEVEL: assert property (
    irq == (ctrl_rdata[fspc_pkg::B_IE] && !ctrl_rdata[fspc_pkg::B_EN]))
    else $error("irq level does not follow enable and op-enable");
  AST_LOCK_READ_ACK: assert property (
    lpm && ctrl_rdata[4:0] == fspc_pkg::CMD_LOCK && !ee_busy |=> rd_ack)
    else $error("lock read gave no answer one cycle after load");
  AST_READ_CLEARS_EN: assert property (
    rd_ack |-> ##[0:1] !ctrl_rdata[fspc_pkg::B_EN])
    else $error("op-enable not cleared after a lock or fuse read");
  AST_WINDOW_EXPIRE: assert property (
    ctrl_wr && ctrl_wdata[0] && !ee_busy && !ctrl_rdata[0] ##1 (!spm && !lpm) [*4]
    |-> ##[0:1] !ctrl_rdata[fspc_pkg::B_EN])
    else $error("op-enable survived an empty timed window");
  AST_HALT_BLOCKS: assert property (
    halt |-> rww_block)
    else $error("cpu halted without the read section blocked");
  AST_BUSY_FLAG: assert property (
    rww_block |-> ctrl_rdata[fspc_pkg::B_BUSY])
    else $error("busy flag low while read section blocked");
  AST_OP_HOLD: assert property (
    $rose(rww_block) |-> ctrl_rdata[0] [*8])
    else $error("op-enable dropped early in a running operation");
  AST_EE_NO_READ: assert property (
    ee_busy && lpm |=> !rd_ack)
    else $error("fuse or lock read answered during eeprom write");
  AST_REEN_CLEARS: assert property (
    spm && ctrl_rdata[4:0] == fspc_pkg::CMD_REEN && !ee_busy
    |-> ##[1:2] !ctrl_rdata[fspc_pkg::B_BUSY])
    else $error("re-enable did not clear the busy flag");
  AST_HALT_CAUSE: assert property (
    $rose(halt) |-> $past(spm))
    else $error("halt rose without a store one cycle before");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench: host end and controller joined over the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        CLK, SYS_RST, HSEL, HWRITE, EE_BUSY, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, s;
  logic [1:0]  HTRANS, MEM_LOCK;
  logic [2:0]  HSIZE;
  logic [4:0]  BUF_IDX;
  logic [7:0]  FUSE_LO, FUSE_HI;
  logic [15:0] BUF_WORD;
  logic [6:0]  OP_PAGE;
  logic [3:0]  LOCK_BITS;
  int          err_total, checks, cyc;
  fspc_if fspc_if_i();
  // short programming time keeps the run brief
  fspc_dev #(.PROG_CYCLES(20)) fspc_dev_i (.CLK(CLK), .SYS_RST(SYS_RST), .ifc(fspc_if_i),
    .FUSE_LO(FUSE_LO), .FUSE_HI(FUSE_HI), .MEM_LOCK(MEM_LOCK), .BUF_IDX(BUF_IDX),
    .BUF_WORD(BUF_WORD), .OP_ERASE(), .OP_WRITE(), .OP_PAGE(OP_PAGE), .LOCK_BITS(LOCK_BITS));
  fspc_host fspc_host_i (.CLK(CLK), .SYS_RST(SYS_RST), .ifc(fspc_if_i), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .EE_BUSY(EE_BUSY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP));
  fspc_props fspc_props_i (.CLK(CLK), .SYS_RST(SYS_RST), .ctrl_wr(fspc_if_i.ctrl_wr),
    .ctrl_wdata(fspc_if_i.ctrl_wdata), .spm(fspc_if_i.spm), .lpm(fspc_if_i.lpm),
    .ee_busy(fspc_if_i.ee_busy), .ctrl_rdata(fspc_if_i.ctrl_rdata),
    .rd_ack(fspc_if_i.rd_ack), .halt(fspc_if_i.halt), .rww_block(fspc_if_i.rww_block),
    .irq(fspc_if_i.irq));
  ////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single ahb transfer, held until hready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= 32'(a);
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000, s);
  endtask
  // control value, pointer, data pair, then launch
  task automatic op(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d,
                    input logic [2:0] g);
    wr(8'h00, 32'(c));
    wr(8'h04, 32'(z));
    wr(8'h08, 32'(d));
    wr(8'h0C, 32'(g));
    // let the launched sequence reach the link before status is read
    repeat (4) @(posedge CLK);
  endtask
  // poll result until its valid bit is seen
  task automatic res;
    for (int n = 0; n < 100; n++) begin
      rd(8'h14);
      if (s[8] === 1'b1) break;
    end
  endtask
  // poll status until op-enable drops
  task automatic idle;
    for (int n = 0; n < 100; n++) begin
      rd(8'h10);
      if (s[0] === 1'b0) break;
    end
  endtask
  task automatic peek(input logic [4:0] i);
    BUF_IDX <= i;
    repeat (2) @(posedge CLK);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] eb [3];
    HSEL = 1'b0; HADDR = 32'h0000_0000; HTRANS = 2'h0; HWRITE = 1'b0; HSIZE = 3'h2;
    HWDATA = 32'h0000_0000; EE_BUSY = 1'b0; FUSE_LO = 8'h5A; FUSE_HI = 8'hA5;
    MEM_LOCK = 2'h2; BUF_IDX = 5'h00; SYS_RST = 1'b1; err_total = 0; checks = 0; cyc = 0;
    eb = '{8'h5A, 8'hFE, 8'hA5};
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    // fuse low, lock, fuse high reads
    for (int i = 0; i < 3; i++) begin
      op(8'h09, (i == 2) ? 16'h0003 : 16'(i), 16'h0000, 3'h5);
      rd(8'h14);
      chk("read byte", {23'h00_0000, 1'b1, eb[i]}, s);
      rd(8'h10);
      chk("op enable", 32'h0000_0000, 32'(s[0]));
    end
    $display("test reads done");
    // lock set, bits 3:2 of data zero
    op(8'h09, 16'h0001, 16'h00F3, 3'h3);
    rd(8'h10);
    chk("lock status", 32'h0000_0001, 32'({s[10:9], s[0]}));
    idle();
    chk("lock bits", 32'h0000_000C, 32'(LOCK_BITS));
    op(8'h09, 16'h0001, 16'h0000, 3'h5);
    rd(8'h14);
    chk("lock byte", 32'h0000_01F2, s);
    $display("test lock done");
    // load a word, write an rww page
    op(8'h01, 16'h0006, 16'hBEEF, 3'h3);
    peek(5'h03);
    chk("buffer word", 32'h0000_BEEF, 32'(BUF_WORD));
    op(8'h05, 16'h0140, 16'h0000, 3'h3);
    rd(8'h10);
    chk("write status", 32'h0000_0441, s & 32'h0000_0641);
    idle();
    chk("write page", 32'h0000_0005, 32'(OP_PAGE));
    peek(5'h03);
    chk("buffer cleared", 32'h0000_0000, 32'(BUF_WORD));
    rd(8'h10);
    chk("busy kept", 32'h0000_0040, s & 32'h0000_0440);
    op(8'h11, 16'h0000, 16'h0000, 3'h3);
    rd(8'h10);
    chk("reenable", 32'h0000_0000, s & 32'h0000_0440);
    $display("test write done");
    // erase an no_read_while_write_section page, bus stalls while halted
    op(8'h03, 16'h1900, 16'h0000, 3'h3);
    chk("erase page", 32'h0000_0064, 32'(OP_PAGE));
    rd(8'h10);
    chk("erase status", 32'h0000_0040, s & 32'h0000_0641);
    op(8'h11, 16'h0000, 16'h0000, 3'h3);
    $display("test erase done");
    // eeprom write discards buffer and delays read
    op(8'h01, 16'h000E, 16'h1234, 3'h3);
    peek(5'h07);
    chk("buffer word", 32'h0000_1234, 32'(BUF_WORD));
    EE_BUSY <= 1'b1;
    fork
      begin
        repeat (20) @(posedge CLK);
        EE_BUSY <= 1'b0;
      end
    join_none
    op(8'h09, 16'h0000, 16'h0000, 3'h5);
    res();
    chk("late fuse", 32'h0000_015A, s);
    chk("buffer lost", 32'h0000_0000, 32'(BUF_WORD));
    $display("test eeprom done");
    // expired window and lone store do nothing
    op(8'h01, 16'h0012, 16'hCAFE, 3'h1);
    repeat (6) @(posedge CLK);
    rd(8'h10);
    chk("expired cmd", 32'h0000_0000, 32'(s[4:0]));
    wr(8'h0C, 32'h0000_0002);
    peek(5'h09);
    chk("late store", 32'h0000_0000, 32'(BUF_WORD));
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18);
    chk("unmapped", 32'h0000_0000, s);
    $display("test window done");
    // interrupt enable with op-enable clear
    op(8'h80, 16'h0000, 16'h0000, 3'h1);
    rd(8'h10);
    chk("irq on", 32'h0000_0001, 32'(s[11]));
    op(8'h00, 16'h0000, 16'h0000, 3'h1);
    rd(8'h10);
    chk("irq off", 32'h0000_0000, 32'(s[11]));
    $display("test irq done");
    give_verdict();
  end
endmodule
`default_nettype wire

// [verilog/fspc_dev.sv]
// self-programming controller: timed commands, page buffer, lock and fuse reads
// Functional notes
// - erase pattern plus store within four cycles
// - erase halts cpu only for no-rww pages
// - load pattern stores data pair by word
// - buffer cleared on write, re-enable, reset
// - software writes each buffer word once
// - eeprom write during loading discards buffer
// - write pattern plus store programs page
// - write halts cpu only for no-rww pages
// - interrupt held while enabled and op-enable clear
// - rww reads blocked during erase or write
// - busy flag set while rww section busy
// - re-enable command clears the busy flag
// - lock-set store programs zero data bits
// - lock programming keeps whole flash readable
// - software sets lock pointer and spare ones
// - eeprom write blocks programming and fuse reads
// - lock read within three cycles returns byte
// - op-enable auto-clears on read or timeout
// - addresses zero and three return fuse bytes
// - programmed bits read zero, unprogrammed one
// - software checks eeprom busy before writing
// - software keeps the timed window atomic
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fspc_dev #(
  parameter int PAGE_WORDS  = 32,
  parameter int PAGE_BITS   = 7,
  parameter int NO_READ_WHILE_WRITE_SECTION_PAGE   = 96,
  parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  fspc_if.dev                               ifc,
  input  wire logic [7:0]                   FUSE_LO,
  input  wire logic [7:0]                   FUSE_HI,
  input  wire logic [1:0]                   MEM_LOCK,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] BUF_IDX,
  output logic      [15:0]                  BUF_WORD,
  output logic                              OP_ERASE,
  output logic                              OP_WRITE,
  output logic      [PAGE_BITS-1:0]         OP_PAGE,
  output logic      [fspc_pkg::LOCK_W-1:0]  LOCK_BITS
);
  localparam int WB = $clog2(PAGE_WORDS);          // word field width
  localparam int CW = $clog2(PROG_CYCLES + 1);     // timer width
  localparam int BW = PAGE_WORDS * 16;             // buffer width
  localparam logic [CW-1:0] T_LOAD = CW'(PROG_CYCLES);
  localparam logic [CW-1:0] T_ONE  = CW'(1);
  localparam logic [PAGE_BITS-1:0] NO_READ_WHILE_WRITE_SECTION = PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE);
  localparam logic [2:0] WIN_ONE = 3'h1;
  localparam int LOCK_W_L = fspc_pkg::LOCK_W;
  localparam logic [LOCK_W_L-1:0] LOCK_INIT = '1;

  typedef enum logic [1:0] {OP_IDLE, OP_ERS, OP_WRT, OP_LCK} fspc_op_e;

  typedef struct packed {
    logic                 ie;        // interrupt enable
    logic                 busy;      // rww busy flag
    logic [4:0]           cmd;       // command bits, bit 0 is op-enable
    logic [2:0]           spm_win;   // store window left
    logic [2:0]           lpm_win;   // load window left
    fspc_op_e             op;        // running operation
    logic [CW-1:0]        timer;     // cycles left
    logic [PAGE_BITS-1:0] page;      // latched page
    logic [LOCK_W_L-1:0]  pend;      // lock data to program
    logic [LOCK_W_L-1:0]  lock;      // boot lock bits, 1 unprogrammed
    logic                 halt;      // cpu halt
    logic                 block;     // rww read block
    logic                 irq;       // interrupt out
    logic [7:0]           rd_data;   // special read result
    logic                 rd_ack;    // special read pulse
    logic                 erase_p;   // erase done pulse
    logic                 write_p;   // write done pulse
    logic                 ee_q;      // eeprom busy last cycle
    logic [15:0]          buf_word;  // buffer read port
    logic [BW-1:0]        pbuf;      // temporary page buffer
  } fspc_dev_s;

  fspc_dev_s r_reg;  // present state
  fspc_dev_s r_next; // next state

  // page field of the pointer
  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
    page_of = z[WB+1 +: PAGE_BITS];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.erase_p = 1'b0;
    r_next.write_p = 1'b0;
    r_next.rd_ack  = 1'b0;
    // windows count down
    if (r_reg.spm_win != 3'h0) begin
      r_next.spm_win = r_reg.spm_win - WIN_ONE;
    end
    if (r_reg.lpm_win != 3'h0) begin
      r_next.lpm_win = r_reg.lpm_win - WIN_ONE;
    end
    // both windows gone with nothing running
    if (r_reg.op == OP_IDLE && r_next.spm_win == 3'h0 && r_next.lpm_win == 3'h0) begin
      r_next.cmd = 5'h00;
    end
    // control write; commands refused while an operation runs or eeprom writing
    if (ifc.ctrl_wr) begin
      r_next.ie = ifc.ctrl_wdata[fspc_pkg::B_IE];
      if (r_reg.op == OP_IDLE && !ifc.ee_busy) begin
        r_next.cmd = ifc.ctrl_wdata[4:0];
        if (ifc.ctrl_wdata[fspc_pkg::B_EN]) begin
          r_next.spm_win = fspc_pkg::SPM_WIN;
          r_next.lpm_win = fspc_pkg::LPM_WIN;
        end
      end
    end
    // store instruction inside its window
    if (ifc.spm && r_reg.cmd[fspc_pkg::B_EN] && r_reg.spm_win != 3'h0
        && r_reg.op == OP_IDLE && !ifc.ee_busy) begin
      r_next.spm_win = 3'h0;
      r_next.lpm_win = 3'h0;
      unique case (r_reg.cmd)
        fspc_pkg::CMD_ERASE, fspc_pkg::CMD_WRITE: begin
          r_next.op    = (r_reg.cmd == fspc_pkg::CMD_ERASE) ? OP_ERS : OP_WRT;
          r_next.page  = page_of(ifc.z);
          r_next.timer = T_LOAD;
          r_next.halt  = page_of(ifc.z) >= NO_READ_WHILE_WRITE_SECTION;
          r_next.block = 1'b1;
          r_next.busy  = 1'b1;
        end
        fspc_pkg::CMD_LOCK: begin
          r_next.op    = OP_LCK;
          r_next.pend  = ifc.data[fspc_pkg::LOCK_LSB +: LOCK_W_L];
          r_next.timer = T_LOAD;
        end
        fspc_pkg::CMD_LOAD: begin
          r_next.pbuf[ifc.z[WB:1]*16 +: 16] = ifc.data;
          r_next.cmd = 5'h00;
        end
        fspc_pkg::CMD_REEN: begin
          r_next.busy  = 1'b0;
          r_next.pbuf  = '0;
          r_next.block = 1'b0;
          r_next.cmd   = 5'h00;
        end
        default: begin
          r_next.cmd = 5'h00; // unknown pattern, drop it
        end
      endcase
    end
    // lock or fuse read inside its window
    if (ifc.lpm && r_reg.cmd == fspc_pkg::CMD_LOCK && r_reg.lpm_win != 3'h0
        && r_reg.op == OP_IDLE && !ifc.ee_busy) begin
      r_next.rd_ack  = 1'b1;
      r_next.cmd     = 5'h00;
      r_next.spm_win = 3'h0;
      r_next.lpm_win = 3'h0;
      unique case (ifc.z)
        fspc_pkg::Z_LOCK:    r_next.rd_data = {fspc_pkg::TOP_ONES, r_reg.lock, MEM_LOCK};
        fspc_pkg::Z_FUSE_LO: r_next.rd_data = FUSE_LO;
        fspc_pkg::Z_FUSE_HI: r_next.rd_data = FUSE_HI;
        default:             r_next.rd_data = 8'hFF;
      endcase
    end
    // running operation keeps op-enable set until done, unless its store came in the last store-window cycle
    if (r_reg.op != OP_IDLE) begin
      if (r_reg.timer == T_ONE) begin
        r_next.op    = OP_IDLE;
        r_next.cmd   = 5'h00;
        r_next.halt  = 1'b0;
        r_next.block = 1'b0; // busy flag stays until re-enable
        r_next.erase_p = (r_reg.op == OP_ERS);
        r_next.write_p = (r_reg.op == OP_WRT);
        if (r_reg.op == OP_WRT) begin
          r_next.pbuf = '0;
        end
        if (r_reg.op == OP_LCK) begin
          r_next.lock = r_reg.lock & r_reg.pend;
        end
      end else begin
        r_next.timer = r_reg.timer - T_ONE;
      end
    end
    // eeprom write starting mid-load loses the buffer
    r_next.ee_q = ifc.ee_busy;
    if (ifc.ee_busy && !r_reg.ee_q) begin
      r_next.pbuf = '0;
    end
    r_next.irq      = r_next.ie && !r_next.cmd[fspc_pkg::B_EN];
    r_next.buf_word = r_reg.pbuf[BUF_IDX*16 +: 16];
  end

  //////////////////////////////////////////////////////////////////////////
  // state register, reset clears buffer too
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_reg      <= '0;
      r_reg.op   <= OP_IDLE;
      r_reg.lock <= LOCK_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign ifc.ctrl_rdata = {r_reg.ie, r_reg.busy, 1'b0, r_reg.cmd};
  assign ifc.rd_data    = r_reg.rd_data;
  assign ifc.rd_ack     = r_reg.rd_ack;
  assign ifc.halt       = r_reg.halt;
  assign ifc.rww_block  = r_reg.block;
  assign ifc.irq        = r_reg.irq;
  assign BUF_WORD       = r_reg.buf_word;
  assign OP_ERASE       = r_reg.erase_p;
  assign OP_WRITE       = r_reg.write_p;
  assign OP_PAGE        = r_reg.page;
  assign LOCK_BITS      = r_reg.lock;
endmodule
`default_nettype wire

// [verilog/fspc_host.sv]
// processor-core end: ahb-lite registers that drive the timed sequences
`timescale 1ns/1ns
`default_nettype none
module fspc_host (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  fspc_if.host             ifc,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        EE_BUSY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);
  typedef enum logic [1:0] {S_IDLE, S_CTRL, S_INSTR} fspc_seq_e;

  typedef struct packed {
    logic        ap_valid;  // data phase pending
    logic        ap_write;  // pending is a write
    logic [2:0]  ap_idx;    // pending register index
    logic        hready;    // ready out
    logic [31:0] hrdata;    // read data out
    logic [7:0]  ctrl_val;  // control value to send
    logic [15:0] z;         // pointer
    logic [15:0] data;      // data pair
    logic [2:0]  go;        // launched steps
    fspc_seq_e   seq;       // sequencer
    logic        ctrl_wr;   // strobe
    logic        spm;       // strobe
    logic        lpm;       // strobe
    logic [7:0]  res;       // last lock or fuse byte
    logic        res_ok;    // result valid
  } fspc_host_s;

  fspc_host_s r_reg;  // present state
  fspc_host_s r_next; // next state

  // register read mux
  function automatic logic [31:0] rd(input fspc_host_s s, input logic [2:0] i);
    rd = 32'h0000_0000;
    unique case (i)
      fspc_pkg::IDX_CTRL: rd[7:0]  = s.ctrl_val;
      fspc_pkg::IDX_Z:    rd[15:0] = s.z;
      fspc_pkg::IDX_DATA: rd[15:0] = s.data;
      fspc_pkg::IDX_GO:   rd[2:0]  = s.go;
      fspc_pkg::IDX_STAT: rd[11:0] = {ifc.irq, ifc.rww_block, ifc.halt, EE_BUSY,
                                      ifc.ctrl_rdata};
      fspc_pkg::IDX_RES:  rd[8:0]  = {s.res_ok, s.res};
      default:            rd = 32'h0000_0000;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus slave and sequencer
  always_comb begin
    r_next = r_reg;
    r_next.ctrl_wr = 1'b0;
    r_next.spm     = 1'b0;
    r_next.lpm     = 1'b0;
    // finished data phase: apply write
    if (r_reg.ap_valid && r_reg.hready) begin
      r_next.ap_valid = 1'b0;
      if (r_reg.ap_write) begin
        unique case (r_reg.ap_idx)
          fspc_pkg::IDX_CTRL: r_next.ctrl_val = HWDATA[7:0];
          fspc_pkg::IDX_Z:    r_next.z = HWDATA[15:0];
          fspc_pkg::IDX_DATA: r_next.data = HWDATA[15:0];
          fspc_pkg::IDX_GO: begin
            r_next.go     = HWDATA[2:0];
            r_next.seq    = S_CTRL;
            r_next.res_ok = 1'b0;
          end
          default: r_next.go = r_reg.go; // unmapped, ignored
        endcase
      end
    end
    // new address phase
    if (HSEL && HTRANS[1] && HREADY) begin
      r_next.ap_valid = 1'b1;
      r_next.ap_write = HWRITE;
      r_next.ap_idx   = (HADDR[31:5] == 27'h000_0000) ? HADDR[4:2] : fspc_pkg::IDX_NONE;
    end
    // sequencer: control write then the instruction next cycle
    unique case (r_reg.seq)
      S_IDLE: r_next.seq = r_next.seq;
      S_CTRL: begin
        if (!r_reg.go[fspc_pkg::GO_CTRL]) begin
          r_next.seq = S_INSTR;
        end else if (!EE_BUSY) begin
          r_next.ctrl_wr = 1'b1;
          r_next.seq     = S_INSTR;
        end
      end
      S_INSTR: begin
        r_next.spm = r_reg.go[fspc_pkg::GO_SPM];
        r_next.lpm = r_reg.go[fspc_pkg::GO_LPM];
        r_next.seq = S_IDLE;
      end
    endcase
    // capture lock or fuse result
    if (ifc.rd_ack) begin
      r_next.res    = ifc.rd_data;
      r_next.res_ok = 1'b1;
    end
    // stall while sequencing or while the cpu is halted
    r_next.hready = (r_next.seq == S_IDLE) && !ifc.halt;
    r_next.hrdata = rd(r_next, r_next.ap_idx);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_reg        <= '0;
      r_reg.seq    <= S_IDLE;
      r_reg.hready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign HRDATA         = r_reg.hrdata;
  assign HREADYOUT      = r_reg.hready;
  assign HRESP          = 1'b0;
  assign ifc.ctrl_wr    = r_reg.ctrl_wr;
  assign ifc.ctrl_wdata = r_reg.ctrl_val;
  assign ifc.spm        = r_reg.spm;
  assign ifc.lpm        = r_reg.lpm;
  assign ifc.z          = r_reg.z;
  assign ifc.data       = r_reg.data;
  assign ifc.ee_busy    = EE_BUSY;
endmodule
`default_nettype wire

// [verilog/fspc_if.sv]
// link between the processor-core end and the self-programming controller
`timescale 1ns/1ns
`default_nettype none
interface fspc_if;
  logic        ctrl_wr;     // control register write strobe
  logic [7:0]  ctrl_wdata;  // control register write value
  logic        spm;         // store-program-memory strobe
  logic        lpm;         // load-program-memory strobe
  logic [15:0] z;           // address pointer
  logic [15:0] data;        // data pair, high:low
  logic        ee_busy;     // eeprom write in progress
  logic [7:0]  ctrl_rdata;  // control register contents
  logic [7:0]  rd_data;     // lock or fuse byte
  logic        rd_ack;      // rd_data valid, one cycle
  logic        halt;        // cpu halted
  logic        rww_block;   // read-while-write section blocked
  logic        irq;         // completion interrupt level
  modport dev  (input ctrl_wr, ctrl_wdata, spm, lpm, z, data, ee_busy,
                output ctrl_rdata, rd_data, rd_ack, halt, rww_block, irq);
  modport host (output ctrl_wr, ctrl_wdata, spm, lpm, z, data, ee_busy,
                input ctrl_rdata, rd_data, rd_ack, halt, rww_block, irq);
endinterface
`default_nettype wire

// [verilog/fspc_pkg.sv]
// shared constants for the flash self-programming controller and its host
package fspc_pkg;
  // clock and programming time
  localparam int CLK_HZ       = 20_000_000;
  localparam int PROG_TIME_US = 3700;             // least programming time
  localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_HZ / 1_000_000);
  // timed windows after a control write
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] LPM_WIN = 3'h3;
  // control register bit positions
  localparam int B_EN   = 0;
  localparam int B_REEN = 4;
  localparam int B_BUSY = 6;
  localparam int B_IE   = 7;
  // command patterns in control bits 4:0
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;
  // special read addresses
  localparam logic [15:0] Z_FUSE_LO = 16'h0000;
  localparam logic [15:0] Z_LOCK    = 16'h0001;
  localparam logic [15:0] Z_FUSE_HI = 16'h0003;
  // boot lock field in data and lock byte
  localparam int LOCK_LSB = 2;
  localparam int LOCK_W   = 4;
  localparam logic [1:0] TOP_ONES = 2'h3;
  // host register word indexes (byte address = index * 4)
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_Z    = 3'h1;
  localparam logic [2:0] IDX_DATA = 3'h2;
  localparam logic [2:0] IDX_GO   = 3'h3;
  localparam logic [2:0] IDX_STAT = 3'h4;
  localparam logic [2:0] IDX_RES  = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  // go register bits
  localparam int GO_CTRL = 0;
  localparam int GO_SPM  = 1;
  localparam int GO_LPM  = 2;
endpackage
